// [verilog/rim_pkg.sv]
// constants, types and helpers shared by the register integrity monitor
//------------------------------------------------------------------------------
// Function
// - the fuse shadow array is checked by a 3-bit crc, polynomial x^3+x+1, seed 111.
// - a shadow array crc mismatch sets the internal fault flag.
// - the writable config array is checked by the same 3-bit crc with the same seed.
// - the config array check runs only while the init complete lock is set.
// - a config array crc mismatch sets the internal fault flag.
// - a digital regulator failure either sets reset occurred or holds the device in reset.
// - an analog regulator failure sets reset occurred and the device keeps answering.
// - loss of either ground is seen as a regulator failure and forces device reset.
// - three key writes in the defined order to the two soft reset key bits start a reset.
// - an 8-bit free-running counter steps every 1024 oscillator cycles, 10-bit prescaler.
// - the counter is read-only: host reads return its value, nothing writes it.
// - status reads clear the fault; config faults return until reset, fuse faults only while the crc mismatches.
// - reset occurred is set in initialisation after any reset, cleared by a status read.
//------------------------------------------------------------------------------
package rim_pkg;

  //----------------------------------------------------------------------------
  // array sizes and crc
  //----------------------------------------------------------------------------
  localparam int               SHADOW_BITS = 64;
  localparam int               CFG_BITS    = 48;
  localparam logic [2:0]       CRC_SEED    = 3'h7;
  localparam logic [2:0]       CRC_POLY    = 3'h3;

  //----------------------------------------------------------------------------
  // oscillator monitor
  //----------------------------------------------------------------------------
  localparam int               PRESC_BITS  = 10;
  localparam int               COUNT_BITS  = 8;
  localparam logic [9:0]       PRESC_LAST  = 10'h3FF;
  localparam logic [9:0]       PRESC_RESET = 10'h000;
  localparam logic [7:0]       COUNT_RESET = 8'h00;

  //----------------------------------------------------------------------------
  // status byte layout and initialisation
  //----------------------------------------------------------------------------
  localparam int               STAT_RESOCC_POS = 0;
  localparam int               STAT_INIT_POS   = 4;
  localparam int               STAT_FAULT_POS  = 6;
  localparam logic [3:0]       INIT_CYCLES     = 4'hF;

  //----------------------------------------------------------------------------
  // soft reset key sequence, value is {key_hi, key_lo}
  //----------------------------------------------------------------------------
  localparam logic [1:0]       KEY_STEP1 = 2'h0;
  localparam logic [1:0]       KEY_STEP2 = 2'h2;
  localparam logic [1:0]       KEY_STEP3 = 2'h1;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] count;
  } rim_snap_t;

  typedef struct packed {
    logic dreg_fail;
    logic areg_fail;
    logic dgnd_loss;
    logic agnd_loss;
  } rim_supply_t;

  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_TWO} rim_key_state_t;

  // one msb-first step of the x^3+x+1 crc
  function automatic logic [2:0] rim_crc3_step(input logic [2:0] crc, input logic din);
    logic fb;
    fb = crc[2] ^ din;
    return {crc[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
  endfunction

endpackage

// [verilog/rim_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rim_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // crossing
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds q only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // rim_sync2
`default_nettype wire

// [verilog/rim_crc3.sv]
// bit-serial 3-bit crc checker that repeats over a register array
`timescale 1ns/1ps
`default_nettype none
module rim_crc3
  import rim_pkg::*;
#(
  parameter int NBITS = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // array under check
  input  wire logic             en,
  input  wire logic [NBITS-1:0] data,
  input  wire logic [2:0]       stored_crc,
  // result
  output var  logic             done,
  output var  logic             mismatch
);
  localparam int IW = $clog2(NBITS + 1);
  localparam logic [IW-1:0] LAST = IW'(NBITS);

  logic [IW-1:0]    idx;
  logic [2:0]       crc;
  logic [NBITS-1:0] shreg;
  wire              at_end   = (idx == LAST);
  wire  [2:0]       next_crc = rim_crc3_step(crc, shreg[NBITS-1]);

  // array is re-sampled at every pass start so edits are caught next pass
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idx      <= '0;
      crc      <= CRC_SEED;
      shreg    <= '0;
      done     <= 1'b0;
      mismatch <= 1'b0;
    end else if (!en) begin
      idx      <= '0;
      crc      <= CRC_SEED;
      shreg    <= data;
      done     <= 1'b0;
      mismatch <= 1'b0;
    end else if (at_end) begin
      idx      <= '0;
      crc      <= CRC_SEED;
      shreg    <= data;
      done     <= 1'b1;
      mismatch <= (crc != stored_crc);
    end else begin
      idx      <= idx + IW'(1);
      crc      <= next_crc;
      shreg    <= {shreg[NBITS-2:0], 1'b0};
      done     <= 1'b0;
      mismatch <= 1'b0;
    end
  end

  seed_reload_a: assert property (@(posedge mclk) disable iff (!arst_n)
    done |-> crc == CRC_SEED && idx == '0) else $error("crc not reseeded after pass");
  pass_len_a: assert property (@(posedge mclk) disable iff (!arst_n)
    done |=> !done) else $error("crc pass shorter than two cycles");
endmodule // rim_crc3
`default_nettype wire

// [verilog/rim_top.sv]
// register integrity monitor: crc checks, reset sources, oscillator counter, host link
`timescale 1ns/1ps
`default_nettype none
module rim_top
  import rim_pkg::*;
(
  // clocks and reset
  input  wire logic                   mclk,
  input  wire logic                   lclk,
  input  wire logic                   arst_n,
  // fuse shadow and writable arrays
  input  wire logic [SHADOW_BITS-1:0] otp_bits,
  input  wire logic [2:0]             otp_crc,
  input  wire logic [CFG_BITS-1:0]    cfg_bits,
  input  wire logic [2:0]             cfg_crc,
  input  wire logic                   init_complete_lock,
  input  wire logic                   dreg_hold_mode,
  // supply monitor pins
  input  wire rim_supply_t            supply_pins,
  // host link, lclk domain
  input  wire logic                   rd_req,
  input  wire logic                   rd_status_kind,
  input  wire logic                   key_wr,
  input  wire logic                   soft_reset_key_hi,
  input  wire logic                   soft_reset_key_lo,
  output var  logic                   rd_valid,
  output var  rim_snap_t              rd_data,
  output var  logic                   rd_busy,
  // status, mclk domain
  output var  logic                   internal_fault_flag,
  output var  logic                   reset_occurred_flag,
  output var  logic                   init_busy,
  output var  logic                   dev_in_reset,
  output var  logic [COUNT_BITS-1:0]  osc_count
);

  //----------------------------------------------------------------------------
  // crossings into mclk
  //----------------------------------------------------------------------------
  rim_supply_t     supply_s;
  logic            req_tgl;
  logic            sr_tgl;
  logic            req_s;
  logic            sr_s;
  logic            req_d;
  logic            sr_d;

  rim_sync2 #(.W(6)) u_sync_m (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      ({supply_pins, req_tgl, sr_tgl}),
    .q      ({supply_s, req_s, sr_s})
  );

  wire rd_evt   = req_s ^ req_d;
  wire sr_evt   = sr_s ^ sr_d;
  wire gnd_any  = supply_s.dgnd_loss | supply_s.agnd_loss;
  wire dreg_rst = supply_s.dreg_fail & dreg_hold_mode;
  // ground loss always ends in reset, a digital regulator fault only in hold mode, an analog one never
  wire rst_cause = gnd_any | dreg_rst | sr_evt;

  //----------------------------------------------------------------------------
  // device reset and initialisation
  //----------------------------------------------------------------------------
  logic [3:0] init_cnt;
  wire  [3:0] next_init_cnt = rst_cause ? INIT_CYCLES :
                              (init_cnt != 4'h0) ? init_cnt - 4'h1 : 4'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dev_in_reset <= 1'b1;
      init_cnt     <= INIT_CYCLES;
      init_busy    <= 1'b1;
    end else begin
      dev_in_reset <= rst_cause;
      init_cnt     <= next_init_cnt;
      init_busy    <= rst_cause | (next_init_cnt != 4'h0);
    end
  end

  //----------------------------------------------------------------------------
  // crc engines
  //----------------------------------------------------------------------------
  logic otp_done;
  logic otp_mis;
  logic cfg_done;
  logic cfg_mis;
  logic cfg_fault_latched;
  wire  crc_run = !rst_cause && !init_busy;
  wire  cfg_run = crc_run && init_complete_lock;

  rim_crc3 #(.NBITS(SHADOW_BITS)) u_crc_otp (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .en         (crc_run),
    .data       (otp_bits),
    .stored_crc (otp_crc),
    .done       (otp_done),
    .mismatch   (otp_mis)
  );

  rim_crc3 #(.NBITS(CFG_BITS)) u_crc_cfg (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .en         (cfg_run),
    .data       (cfg_bits),
    .stored_crc (cfg_crc),
    .done       (cfg_done),
    .mismatch   (cfg_mis)
  );

  //----------------------------------------------------------------------------
  // status flags
  //----------------------------------------------------------------------------
  logic stat_kind;
  wire  stat_clr   = rd_evt & stat_kind;
  // fuse faults come back every pass, config faults stay latched until reset
  wire  fault_set  = otp_mis | cfg_mis | cfg_fault_latched;
  wire  resocc_set = init_busy | supply_s.areg_fail
                   | (supply_s.dreg_fail & !dreg_hold_mode);
  wire  next_fault  = fault_set | (internal_fault_flag & !stat_clr);
  wire  next_resocc = resocc_set | (reset_occurred_flag & !stat_clr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_fault_latched   <= 1'b0;
      internal_fault_flag <= 1'b0;
      reset_occurred_flag <= 1'b1;
    end else begin
      cfg_fault_latched   <= cfg_mis | (cfg_fault_latched & !rst_cause);
      internal_fault_flag <= next_fault;
      reset_occurred_flag <= next_resocc;
    end
  end

  //----------------------------------------------------------------------------
  // oscillator monitor
  //----------------------------------------------------------------------------
  logic [PRESC_BITS-1:0] presc;
  wire                   presc_wrap = (presc == PRESC_LAST);

  // no write path exists, so the count can only be read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      presc     <= PRESC_RESET;
      osc_count <= COUNT_RESET;
    end else if (rst_cause) begin
      presc     <= PRESC_RESET;
      osc_count <= COUNT_RESET;
    end else begin
      presc     <= presc + 10'h001;
      osc_count <= presc_wrap ? osc_count + 8'h01 : osc_count;
    end
  end

  //----------------------------------------------------------------------------
  // read snapshot, handed back by toggle handshake
  //----------------------------------------------------------------------------
  logic [7:0] status_byte;
  rim_snap_t  snap;
  logic       ack_tgl;

  always_comb begin
    status_byte                  = 8'h00;
    status_byte[STAT_RESOCC_POS] = reset_occurred_flag;
    status_byte[STAT_INIT_POS]   = init_busy;
    status_byte[STAT_FAULT_POS]  = internal_fault_flag;
  end

  // stat_kind is a link flop held steady while the request is pending
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_d     <= 1'b0;
      sr_d      <= 1'b0;
      ack_tgl   <= 1'b0;
      snap      <= '0;
    end else begin
      req_d     <= req_s;
      sr_d      <= sr_s;
      ack_tgl   <= ack_tgl ^ rd_evt;
      snap      <= rd_evt ? {status_byte, osc_count} : snap;
    end
  end

  //----------------------------------------------------------------------------
  // link side, lclk domain
  //----------------------------------------------------------------------------
  logic           ack_s;
  logic           ack_d;
  rim_key_state_t key_state;
  rim_key_state_t next_key_state;
  wire  [1:0]     key_val = {soft_reset_key_hi, soft_reset_key_lo};
  wire            rd_take = rd_req & !rd_busy;
  wire            ack_evt = ack_s ^ ack_d;
  wire            key_hit = key_wr && key_state == KEY_TWO && key_val == KEY_STEP3;

  rim_sync2 #(.W(1)) u_sync_l (
    .clk    (lclk),
    .arst_n (arst_n),
    .d      (ack_tgl),
    .q      (ack_s)
  );

  always_comb begin
    next_key_state = key_state;
    if (key_wr) begin
      case (key_state)
        KEY_IDLE: next_key_state = (key_val == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
        KEY_ONE:  next_key_state = (key_val == KEY_STEP2) ? KEY_TWO :
                                   (key_val == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
        KEY_TWO:  next_key_state = (key_val == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
        default:  next_key_state = KEY_IDLE;
      endcase
    end
  end

  // a second request while one is pending is dropped, not queued
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      key_state <= KEY_IDLE;
      sr_tgl    <= 1'b0;
      req_tgl   <= 1'b0;
      stat_kind <= 1'b0;
      ack_d     <= 1'b0;
      rd_busy   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end else begin
      key_state <= next_key_state;
      sr_tgl    <= sr_tgl ^ key_hit;
      req_tgl   <= req_tgl ^ rd_take;
      stat_kind <= rd_take ? rd_status_kind : stat_kind;
      ack_d     <= ack_s;
      rd_busy   <= rd_take | (rd_busy & !ack_evt);
      rd_valid  <= ack_evt;
      rd_data   <= ack_evt ? snap : rd_data;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  otp_fault_a: assert property (@(posedge mclk) disable iff (!arst_n)
    otp_mis |=> internal_fault_flag) else $error("fuse crc fault not flagged");
  cfg_fault_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_mis |=> internal_fault_flag && cfg_fault_latched) else $error("cfg crc fault lost");
  lock_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !init_complete_lock [*2] |-> !cfg_mis) else $error("cfg crc ran while unlocked");
  fault_stick_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_fault_latched && !rst_cause |=> ##1 internal_fault_flag)
    else $error("cfg fault not reasserted");
  read_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    stat_clr && !fault_set |=> !internal_fault_flag) else $error("status read kept fault");
  areg_resocc_a: assert property (@(posedge mclk) disable iff (!arst_n)
    supply_s.areg_fail && !rst_cause |=> reset_occurred_flag && !dev_in_reset)
    else $error("analog fault handling wrong");
  dreg_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    supply_s.dreg_fail |=> (dreg_hold_mode ? dev_in_reset : reset_occurred_flag))
    else $error("digital fault handling wrong");
  gnd_reset_a: assert property (@(posedge mclk) disable iff (!arst_n)
    gnd_any |=> dev_in_reset ##1 init_busy) else $error("ground loss did not reset");
  soft_reset_a: assert property (@(posedge lclk) disable iff (!arst_n)
    key_hit |=> sr_tgl != $past(sr_tgl) && key_state == KEY_IDLE)
    else $error("key sequence not taken");
  key_order_a: assert property (@(posedge lclk) disable iff (!arst_n)
    !key_hit |=> $stable(sr_tgl)) else $error("soft reset without key sequence");
  // reset cause is combinational, so its effects are checked one cycle later
  dreg_soft_a: assert property (@(posedge mclk) disable iff (!arst_n)
    supply_s.dreg_fail && !dreg_hold_mode && !gnd_any && !sr_evt |=> !dev_in_reset)
    else $error("digital fault reset in flag mode");
  cfg_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_done |-> $past(init_complete_lock))
    else $error("cfg crc pass ended while unlocked");
  cfg_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rst_cause && !cfg_mis |=> !cfg_fault_latched)
    else $error("cfg fault survived device reset");
  count_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_evt && !stat_kind && internal_fault_flag |=> internal_fault_flag)
    else $error("count read cleared the fault");
  resocc_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    stat_clr && !resocc_set |=> !reset_occurred_flag)
    else $error("status read kept reset occurred");
  count_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rd_evt |=> snap.count == $past(osc_count))
    else $error("read snapshot lost the count");
  count_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    presc_wrap && !rst_cause |=> osc_count == $past(osc_count) + 8'h01 && presc == 10'h000)
    else $error("counter step wrong");
  count_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !presc_wrap && !rst_cause |=> $stable(osc_count)) else $error("counter moved early");
  count_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    rst_cause |=> osc_count == COUNT_RESET && presc == PRESC_RESET)
    else $error("counter not cleared by reset");
  resocc_init_a: assert property (@(posedge mclk) disable iff (!arst_n)
    init_busy |=> reset_occurred_flag) else $error("reset occurred missing in init");

  otp_fault_c:  cover property (@(posedge mclk) disable iff (!arst_n) otp_mis);
  cfg_fault_c:  cover property (@(posedge mclk) disable iff (!arst_n) cfg_mis);
  soft_reset_c: cover property (@(posedge mclk) disable iff (!arst_n) sr_evt);
  stat_read_c:  cover property (@(posedge lclk) disable iff (!arst_n) rd_valid);
  hold_reset_c: cover property (@(posedge mclk) disable iff (!arst_n) dreg_rst);
endmodule // rim_top
`default_nettype wire

// [dv/rim_host_model.sv]
// host side model of the read and key link
`timescale 1ns/1ps
`default_nettype none
module rim_host_model
  import rim_pkg::*;
(
  // link clock and reset
  input  wire logic      lclk,
  input  wire logic      arst_n,
  // requests
  output var  logic      rd_req,
  output var  logic      rd_status_kind,
  output var  logic      key_wr,
  output var  logic      soft_reset_key_hi,
  output var  logic      soft_reset_key_lo,
  // answers
  input  wire logic      rd_valid,
  input  wire rim_snap_t rd_data,
  input  wire logic      rd_busy
);
  logic [7:0] last_count;

  initial begin
    rd_req = 1'b0;
    rd_status_kind = 1'b0;
    key_wr = 1'b0;
    soft_reset_key_hi = 1'b0;
    soft_reset_key_lo = 1'b1;
    last_count = 8'h00;
  end

  // one request at a time, held across exactly one rising edge
  task automatic read(input logic kind, output rim_snap_t d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(negedge lclk);
    if (arst_n === 1'b1 && rd_busy === 1'b0) begin
      rd_req = 1'b1;
      rd_status_kind = kind;
      @(negedge lclk);
      rd_req = 1'b0;
      rd_status_kind = ~kind;
      for (int n = 0; n < 40 && !ok; n++) begin
        if (rd_valid === 1'b1) begin
          ok = 1'b1;
          d = rd_data;
        end else begin
          @(negedge lclk);
        end
      end
    end
    last_count = d.count;
  endtask

  // three back-to-back key writes, then the key lines invert
  task automatic keys(input logic [1:0] a, input logic [1:0] b, input logic [1:0] c);
    logic [5:0] s;
    s = {a, b, c};
    for (int i = 2; i >= 0; i--) begin
      @(negedge lclk);
      key_wr = 1'b1;
      {soft_reset_key_hi, soft_reset_key_lo} = s[2*i +: 2];
    end
    @(negedge lclk);
    key_wr = 1'b0;
    {soft_reset_key_hi, soft_reset_key_lo} = ~c;
  endtask
endmodule // rim_host_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench of the register integrity monitor
`timescale 1ns/1ps
`default_nettype none
module tb
  import rim_pkg::*;
;
  logic                   mclk, lclk, arst_n;
  logic [SHADOW_BITS-1:0] otp_bits;
  logic [CFG_BITS-1:0]    cfg_bits;
  logic [2:0]             otp_crc, cfg_crc, otp_good, cfg_good;
  logic                   init_complete_lock, dreg_hold_mode;
  rim_supply_t            supply_pins;
  logic                   rd_req, rd_status_kind, key_wr, soft_reset_key_hi, soft_reset_key_lo;
  logic                   rd_valid, rd_busy, ok;
  rim_snap_t              rd_data, d;
  logic                   internal_fault_flag, reset_occurred_flag, init_busy, dev_in_reset;
  logic [COUNT_BITS-1:0]  osc_count, c0;
  int                     n_fail, comparisons;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #3 lclk = ~lclk;
  end

  rim_top u_rim_top (.mclk(mclk), .lclk(lclk), .arst_n(arst_n), .otp_bits(otp_bits),
    .otp_crc(otp_crc), .cfg_bits(cfg_bits), .cfg_crc(cfg_crc),
    .init_complete_lock(init_complete_lock), .dreg_hold_mode(dreg_hold_mode),
    .supply_pins(supply_pins), .rd_req(rd_req), .rd_status_kind(rd_status_kind),
    .key_wr(key_wr), .soft_reset_key_hi(soft_reset_key_hi),
    .soft_reset_key_lo(soft_reset_key_lo), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_busy(rd_busy), .internal_fault_flag(internal_fault_flag),
    .reset_occurred_flag(reset_occurred_flag), .init_busy(init_busy),
    .dev_in_reset(dev_in_reset), .osc_count(osc_count));

  rim_host_model u_rim_host_model (.lclk(lclk), .arst_n(arst_n), .rd_req(rd_req),
    .rd_status_kind(rd_status_kind), .key_wr(key_wr), .soft_reset_key_hi(soft_reset_key_hi),
    .soft_reset_key_lo(soft_reset_key_lo), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_busy(rd_busy));

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  // reference crc, kept apart from the design's own step function
  function automatic logic [2:0] crc_of(input logic [63:0] v, input int n);
    logic [2:0] c;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? 3'h3 : 3'h0);
    return c;
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic idle();
    int n;
    n = 0;
    while ((init_busy !== 1'b0 || dev_in_reset !== 1'b0) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) begin
      chk("init_busy", 16'h0, 16'h1);
      end_of_test();
    end
  endtask

  // sel 1 watches device reset, sel 0 the fault flag
  task automatic watch(input logic sel, input logic exp, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      if ((sel ? dev_in_reset : internal_fault_flag) === 1'b1) seen = 1'b1;
    end
    chk(sel ? "reset_seen" : "fault_seen", {15'h0, exp}, {15'h0, seen});
  endtask

  task automatic srd(input logic [7:0] exp);
    u_rim_host_model.read(1'b1, d, ok);
    chk("rd_valid", 16'h1, {15'h0, ok});
    chk("status", {8'h0, exp}, {8'h0, d.status});
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    n_fail = 0;
    comparisons = 0;
    arst_n = 1'b0;
    otp_bits = 64'hA5C3_0F96_1E2D_7B48;
    cfg_bits = 48'h3C5A_E18F_2B64;
    otp_good = crc_of(otp_bits, 64);
    cfg_good = crc_of({16'h0, cfg_bits}, 48);
    otp_crc = otp_good;
    cfg_crc = cfg_good;
    init_complete_lock = 1'b0;
    dreg_hold_mode = 1'b0;
    supply_pins = '0;
    cyc(3);
    chk("reset_state", 16'h0600, {5'h0, dev_in_reset, reset_occurred_flag,
        internal_fault_flag, osc_count});
    arst_n = 1'b1;
    idle();
    srd(8'h01);
    srd(8'h00);
    watch(1'b0, 1'b0, 150);
    cyc(1);
    c0 = osc_count;
    cyc(1024);
    chk("count_step", {8'h0, c0 + 8'h01}, {8'h0, osc_count});
    u_rim_host_model.read(1'b0, d, ok);
    c0 = u_rim_host_model.last_count;
    cyc(1100);
    u_rim_host_model.read(1'b0, d, ok);
    chk("count_delta", 16'h1, {15'h0, (d.count - c0) inside {8'h01, 8'h02}});
    for (int i = 0; i < 5; i++) begin
      chk("resocc_clear", 16'h0, {15'h0, reset_occurred_flag});
      cyc(1);
      supply_pins = rim_supply_t'((i == 4) ? 4'h8 : 4'h8 >> i);
      dreg_hold_mode = (i == 4);
      cyc(10);
      chk("supply", {14'h0, 1'b1, i >= 2},
          {14'h0, reset_occurred_flag, dev_in_reset});
      supply_pins = '0;
      idle();
      srd(8'h01);
    end
    cyc(1);
    otp_crc = otp_good ^ 3'h1;
    watch(1'b0, 1'b1, 150);
    srd(8'h40);
    watch(1'b0, 1'b1, 150);
    otp_crc = otp_good;
    cyc(150);
    u_rim_host_model.read(1'b0, d, ok);
    srd(8'h40);
    watch(1'b0, 1'b0, 150);
    cfg_crc = cfg_good ^ 3'h4;
    watch(1'b0, 1'b0, 150);
    init_complete_lock = 1'b1;
    watch(1'b0, 1'b1, 150);
    cfg_crc = cfg_good;
    srd(8'h40);
    watch(1'b0, 1'b1, 150);
    // wrong order must leave the device running
    u_rim_host_model.keys(KEY_STEP1, KEY_STEP3, KEY_STEP2);
    watch(1'b1, 1'b0, 40);
    u_rim_host_model.keys(KEY_STEP1, KEY_STEP2, KEY_STEP3);
    watch(1'b1, 1'b1, 40);
    chk("count_after_reset", 16'h0, {8'h0, osc_count});
    chk("resocc_after_reset", 16'h1, {15'h0, reset_occurred_flag});
    idle();
    srd(8'h41);
    watch(1'b0, 1'b0, 150);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
